/* dv/fph_fetch_port_props.sv */
// Purpose: port checks of the fetch port controller
// Assumes: one clock, rst async high
// Notes:   take checks start after the init purge
`timescale 1ns/1ps
`default_nettype none
module fph_fetch_port_props (
    input wire logic        clk, rst, reqWrite, reqFull, rplTake, rplEmpty,
    input wire logic        cmdValid, cmdReady, outValid, outReady, busy,
    input wire logic [7:0]  reqData, rplData, outData,
    input wire logic [31:0] cmdAddr,
    input wire logic [15:0] cmdCount
);
    // ==========
    // checks
    logic       up;
    logic [2:0] nWr;
    wire  [2:0] next_nWr = (nWr == 3'h5) ? 3'h0 : nWr + 3'h1;
    wire  [2:0] nWrNow   = reqWrite ? next_nWr : nWr;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {up, nWr} <= 4'h0;
        else {up, nWr} <= {up | cmdReady, nWrNow};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // one strobe in flight at most, so a write never lands on a full buffer
    a_send_full: assert property (reqWrite |-> !reqFull)
        else $error("write while full");
    a_take_empty: assert property (up && rplTake |-> !rplEmpty)
        else $error("take while empty");
    a_cmd_start: assert property (cmdValid && cmdReady ##1 !reqFull |=> reqWrite)
        else $error("late request");
    a_six_bytes: assert property (cmdReady |-> nWrNow == 3'h0)
        else $error("byte count");
    a_one_cmd: assert property (cmdValid && cmdReady |=> !cmdReady)
        else $error("ready held");
    a_idle_quiet: assert property (cmdReady |=> !reqWrite && !rplTake)
        else $error("idle strobe");
    a_ready_busy: assert property (cmdReady != busy)
        else $error("ready busy");
    a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
        else $error("out dropped");
    cover property (cmdValid && cmdReady);
    cover property (reqFull && !$past(reqFull));
    cover property (outValid && !outReady);
endmodule
`default_nettype wire

/* dv/fph_storage_model.sv */
// Purpose: far side model, storage behind the fetch port
// Assumes: byte at address p is p[7:0] ^ p[15:8]
// Notes:   slow drains requests every 4th, replies every 3rd cycle
`timescale 1ns/1ps
`default_nettype none
module fph_storage_model #(parameter int CAP = 4) (
    input  wire logic       clk, rst, reqWrite, rplTake, slow,
    input  wire logic [7:0] reqData,
    output logic            reqFull, rplEmpty,
    output logic [7:0]      rplData,
    output logic [31:0]     lastAddr,
    output logic [15:0]     lastCount,
    output int              emptyTakes
);
    // ==========
    // storage side bridge
    logic [7:0]  rq [$], pq [$], hd [6], last;
    logic [31:0] p;
    int          nHd, left, t;
    initial emptyTakes = 0;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rq.delete();
            pq = '{8'h3C, 8'hC3, 8'h5A};
            nHd = 0;
            left = 0;
            last = 8'h00;
            reqFull <= 1'b0;
            rplEmpty <= 1'b0;
        end else begin
            t++;
            if (rplTake && rplEmpty) begin
                emptyTakes++;
                rq.delete();
                nHd = 0;
            end else if (rplTake) last = pq.pop_front();
            if (reqWrite) rq.push_back(reqData);
            if (rq.size() > 0 && (!slow || t % 4 == 0)) begin
                hd[nHd] = rq.pop_front();
                nHd++;
            end
            if (nHd == 6) begin
                {lastAddr, lastCount} = {hd[0], hd[1], hd[2], hd[3], hd[4], hd[5]};
                p = lastAddr;
                left = lastCount;
                nHd = 0;
            end
            if (left > 0 && pq.size() < 4 && (!slow || t % 3 == 0)) begin
                pq.push_back(p[7:0] ^ p[15:8]);
                p++;
                left--;
            end
            reqFull <= rq.size() >= CAP && (reqWrite || reqFull);
            rplEmpty <= pq.size() == 0 && (rplTake || rplEmpty);
        end
        // an empty buffer shows the inverse of the last byte, never a stale copy
        rplData <= (pq.size() > 0) ? pq[0] : ~last;
    end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: bench for the fetch port controller
// Assumes: storage model on the far side
// Notes:   purge count first, then rows, then a reset and purge count again
`timescale 1ns/1ps
`default_nettype none
bind fph_fetch_port fph_fetch_port_props u_props (.*);
module tb;
    typedef struct packed {logic [31:0] a; logic [15:0] n; logic s;} fph_row_s;
    logic        clk, rst = 1'b1, cmdValid = 1'b0, outReady = 1'b0, slow = 1'b0;
    logic [31:0] cmdAddr = 32'h0000_0000, lastAddr, p;
    logic [15:0] cmdCount = 16'h0000, lastCount;
    logic [7:0]  reqData, rplData, outData;
    logic        reqWrite, reqFull, rplTake, rplEmpty, cmdReady, outValid, busy;
    int          n_errors = 0, n_tests = 0, emptyTakes;
    fph_row_s    rows [4] = '{'{32'h1234_5678, 16'h0003, 1'b0}, '{32'hA5C3_00FE, 16'h0014, 1'b1},
        '{32'h0000_0001, 16'h0000, 1'b0}, '{32'hFFFF_FFFE, 16'h0004, 1'b0}};
    fph_fetch_port u_dut (.*);
    fph_storage_model #(.CAP(2)) u_far (.*);
    // ==========
    // tasks
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic idle();
        do @(posedge clk); while (cmdReady !== 1'b1);
    endtask
    // a stalled row fills the fifo until it refuses, then drains it
    task automatic fetch(input fph_row_s r);
        {cmdAddr, cmdCount, slow} <= r;
        cmdValid <= 1'b1;
        outReady <= !r.s;
        idle();
        cmdValid <= 1'b0;
        if (r.s) repeat (150) @(posedge clk);
        outReady <= 1'b1;
        for (p = r.a; p != r.a + r.n; ) begin
            @(posedge clk);
            if (outValid === 1'b1 && outReady === 1'b1) begin
                chk(outData === (p[7:0] ^ p[15:8]), "data");
                p++;
            end
        end
        repeat (24) @(posedge clk);
        chk(outValid === 1'b0 && lastAddr === r.a && lastCount === r.n, "request");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        chk(cmdReady === 1'b0 && busy === 1'b1 && reqWrite === 1'b0 && rplTake === 1'b0, "rst");
        rst <= 1'b0;
        idle();
        @(posedge clk);
        chk(emptyTakes == 2, "purge");
        foreach (rows[k]) fetch(rows[k]);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cmdReady === 1'b0 && busy === 1'b1 && outValid === 1'b0, "rst again");
        rst <= 1'b0;
        idle();
        @(posedge clk);
        chk(emptyTakes == 4, "purge");
        fetch(rows[0]);
        wrap_up();
    end
    // the whole run needs well under 3000 cycles
    initial begin
        #60000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire

/* verilog/fph_fetch_port.sv */
// Purpose: controller end of the byte-wide fetch port
// Assumes: storage_side_bridge peripheral on the same clock
// Notes:   user issues address+count, receives bytes through an 8-deep fifo
//
// Contract
// (R1) send a byte only when request-full is low, one-cycle write strobe
// (R2) back-to-back writes allowed while full stays low
// (R3) peripheral raises full the cycle after the filling write
// (R4) peripheral raises full only in response to a write
// (R5) stall further request bytes while full is high
// (R6) take an inbound byte only when empty is low, one-cycle take strobe
// (R7) back-to-back takes allowed while empty stays low
// (R8) peripheral raises empty the cycle after the draining take
// (R9) peripheral raises empty only in response to a take
// (R10) at init drain inbound bytes until empty, then two extra takes
// (R11) peripheral treats take-while-empty as reset of its request buffer
// (R12) after init reset do not wait for request buffer to drain
// (R13) request is six bytes: address msb first, then byte count msb first
// (R14) peripheral reads count bytes from storage at start address
// (R15) peripheral returns exactly the requested byte count
// (R16) raw binary request/reply pairs on the port
// (R17) peripheral returns bytes in ascending storage order
// (R18) all port signals on the rising edge of one clock
`timescale 1ns/1ps
`default_nettype none
module fph_fetch_port #(
    parameter int DEPTH = fph_pkg::FIFO_DEPTH
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    output logic [fph_pkg::BYTE_W-1:0]      reqData,
    output logic                            reqWrite,
    input  wire logic                       reqFull,
    input  wire logic [fph_pkg::BYTE_W-1:0] rplData,
    output logic                            rplTake,
    input  wire logic                       rplEmpty,
    input  wire logic                       cmdValid,
    input  wire logic [fph_pkg::ADDR_W-1:0] cmdAddr,
    input  wire logic [fph_pkg::COUNT_W-1:0] cmdCount,
    output logic                            cmdReady,
    output logic [fph_pkg::BYTE_W-1:0]      outData,
    output logic                            outValid,
    input  wire logic                       outReady,
    output logic                            busy
);
    // ==========================================
    // state
    typedef enum logic [2:0] {
        S_PURGE = 3'b000,
        S_EXTRA = 3'b001,
        S_IDLE  = 3'b010,
        S_SEND  = 3'b011,
        S_RECV  = 3'b100
    } fph_state_e;

    fph_state_e                    state;
    fph_state_e                    next_state;
    logic [2:0]                    idx;
    logic [fph_pkg::ADDR_W-1:0]    addr;
    logic [fph_pkg::COUNT_W-1:0]   left;
    logic                          fifoReady;
    logic                          fifoValid;
    logic [fph_pkg::BYTE_W-1:0]    fifoData;
    logic [fph_pkg::BYTE_W-1:0]    capData;

    // ==========================================
    // decode
    wire [47:0] reqWord  = {addr, left};
    wire [5:0]  shiftAmt = 6'(6'd40 - {idx, 3'b000});
    wire [fph_pkg::BYTE_W-1:0] reqByte = fph_pkg::BYTE_W'(reqWord >> shiftAmt); // [R13]
    // full is sampled on the flop edge; a pending strobe of our own counts as committed
    wire canSend   = (state == S_SEND) && !reqFull && !reqWrite;                 // [R1] [R5]
    // a take in flight may drain the peripheral, so the next one waits a cycle
    wire purgeTake = (state == S_PURGE) && !rplEmpty && !rplTake;                // [R10]
    wire extraTake = (state == S_EXTRA);                                         // [R10] [R11]
    // take only when our own fifo has room, so the user's stall reaches the port
    wire dataTake  = (state == S_RECV) && !rplEmpty && !rplTake && fifoReady
                     && (left != '0);                                            // [R6] [R7]
    wire anyTake   = purgeTake || extraTake || dataTake;
    wire lastSend  = canSend && (idx == fph_pkg::IDX_LAST);

    always_comb begin
        next_state = state;
        case (state)
            S_PURGE: if (rplEmpty) next_state = S_EXTRA;
            S_EXTRA: if (idx == fph_pkg::PURGE_EXTRA - 3'h1) next_state = S_IDLE; // [R12]
            S_IDLE:  if (cmdValid) next_state = S_SEND;
            S_SEND:  if (lastSend) next_state = (left == '0) ? S_IDLE : S_RECV;
            S_RECV:  if (left == '0) next_state = S_IDLE;                       // [R16]
            default: next_state = S_PURGE;
        endcase
    end

    // ==========================================
    // sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_PURGE;
            idx   <= 3'h0;
            addr  <= '0;
            left  <= '0;
        end else begin
            state <= next_state;
            if (state != next_state) begin
                idx <= fph_pkg::IDX_ZERO;
            end else if (extraTake || canSend) begin
                idx <= idx + 3'h1;                                               // [R2]
            end
            if (state == S_IDLE && cmdValid) begin
                addr <= cmdAddr;
                left <= cmdCount;
            end else if (dataTake) begin
                left <= left - 1'b1;
            end
        end
    end

    // ==========================================
    // port flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqData  <= '0;
            reqWrite <= 1'b0;
            rplTake  <= 1'b0;
            cmdReady <= 1'b0;
            busy     <= 1'b1;
            capData  <= '0;
        end else begin
            reqWrite <= canSend;                                                 // [R1] [R18]
            if (canSend) reqData <= reqByte;
            rplTake  <= anyTake;                                                 // [R6] [R18]
            if (dataTake) capData <= rplData;
            cmdReady <= (next_state == S_IDLE) && !(state == S_IDLE && cmdValid);
            busy     <= next_state != S_IDLE;
        end
    end

    // ==========================================
    // capture path: byte taken in cycle n is pushed in cycle n+1
    logic pushPending;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pushPending <= 1'b0;
        else     pushPending <= dataTake;
    end

    // the output stage loads whenever it is empty or being read, so pop then
    wire fifoPop = !outValid || outReady;

    fph_fifo #(
        .WIDTH (fph_pkg::BYTE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inData   (capData),
        .inValid  (pushPending),
        .inReady  (fifoReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // output register stage keeps top outputs on flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outData  <= '0;
            outValid <= 1'b0;
        end else if (!outValid || outReady) begin
            outData  <= fifoData;
            outValid <= fifoValid;
        end
    end
endmodule
`default_nettype wire

/* verilog/fph_fifo.sv */
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes:   first word falls through to the output
`timescale 1ns/1ps
`default_nettype none
module fph_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;
    wire [AW:0]       fill = wrPtr - rdPtr;
    assign inReady  = fill != (AW+1)'(DEPTH);
    assign outValid = fill != '0;
    assign outData  = mem[rdPtr[AW-1:0]];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) wrPtr <= wrPtr + 1'b1;
            if (pop)  rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verilog/fph_pkg.sv */
// Purpose: shared constants for the fetch port request engine
// Assumes: byte-wide fetch port, single clock
// Notes:   request layout is address then byte count, msb first
package fph_pkg;
    localparam int          BYTE_W       = 8;
    localparam int          ADDR_W       = 32;
    localparam int          COUNT_W      = 16;
    localparam int          REQ_BYTES    = 6;
    localparam int          FIFO_DEPTH   = 8;
    localparam logic [2:0]  PURGE_EXTRA  = 3'h2;
    localparam logic [2:0]  IDX_LAST     = 3'h5;
    localparam logic [2:0]  IDX_ZERO     = 3'h0;
endpackage
